// file: pio_pkg.sv
// Constants, register map and carrier types for the port I/O block
// Notes on behaviour
// - A pin is digital when its mode-select bit is one; analog otherwise.
// - Output-mode bit one: push-pull, pad driven high or low by its output value.
// - Output-mode bit zero: open-drain, drives low only for zero, else both drivers off.
// - Weak pull-up on while high-Z; off while driving; all off when global disable set.
// - Digital pins read back the pad level, not the driven value.
// - Open-drain pin pulled low by a zero from its assigned peripheral, else by a latch zero.
// - Skip bit one keeps every crossbar function off that pin.
// - Drive-strength register: one bit per port, all high drive after reset.
// - Mismatch when masked pin levels differ from masked match value, ports 0 and 1.
// - Mismatch works on pin levels whatever the crossbar routing.
// - Mismatch is offered as interrupt source and idle wake-up source.
// - Port registers take byte and bit writes into the output latch.
// - Ordinary port reads return pin levels even for crossbar-assigned pins.
// - Read-modify-write accesses read the latch instead of the pins.
// - First route register: eight enables, reset zero, clock-out down to UART.
// - UART route puts transmit on port 0 pin 4, receive on port 0 pin 5.
// - SPI route takes three or four pins depending on its wire mode.
// - Counter-array field: none, channel 0, channels 0-1, channels 0-2.
// - Second route register holds timer 2/1/0 and counter clock input enables.
// - Until the crossbar is enabled, crossbar pin drivers are forced off.
// - Analog pins read latch zero; receiver, driver and pull-up disabled.
package pio_pkg;

    localparam int NUM_PORTS   = 3;
    localparam int MATCH_PORTS = 2;
    localparam int NUM_PINS    = 24;
    localparam int XBAR_PINS   = 16;

    localparam logic [NUM_PORTS-1:0][7:0] ADDR_LATCH = {8'hA0, 8'h90, 8'h80};
    localparam logic [NUM_PORTS-1:0][7:0] ADDR_MDIN  = {8'hC3, 8'hC2, 8'hC1};
    localparam logic [NUM_PORTS-1:0][7:0] ADDR_MDOUT = {8'hC6, 8'hC5, 8'hC4};
    localparam logic [NUM_PORTS-1:0][7:0] ADDR_SKIP  = {8'hD6, 8'hD5, 8'hD4};
    localparam logic [MATCH_PORTS-1:0][7:0] ADDR_MASK  = {8'hEE, 8'hFE};
    localparam logic [MATCH_PORTS-1:0][7:0] ADDR_MATCH = {8'hED, 8'hFD};
    localparam logic [7:0] ADDR_ROUTE_A = 8'hE1;
    localparam logic [7:0] ADDR_ROUTE_B = 8'hE2;
    localparam logic [7:0] ADDR_XBAR_C  = 8'hF3;
    localparam logic [7:0] ADDR_DRIVE   = 8'hF6;

    localparam logic [7:0] ROUTE_B_RW_MASK = 8'h3F;
    localparam logic [7:0] XBAR_C_RW_MASK  = 8'hC0;
    localparam logic [7:0] DRIVE_RW_MASK   = 8'h07;

    // Route register A bits
    localparam int RA_CLOCK_OUT = 7;
    localparam int RA_CMP1_ASYN = 6;
    localparam int RA_CMP1      = 5;
    localparam int RA_CMP0_ASYN = 4;
    localparam int RA_CMP0      = 3;
    localparam int RA_SMBUS     = 2;
    localparam int RA_SPI       = 1;
    localparam int RA_UART      = 0;
    // Route register B bits
    localparam int RB_TIMER2    = 5;
    localparam int RB_TIMER1    = 4;
    localparam int RB_TIMER0    = 3;
    localparam int RB_CNT_CLOCK = 2;
    localparam int RB_CHAN_HI   = 1;
    localparam int RB_CHAN_LO   = 0;
    // Crossbar control register bits
    localparam int XC_PULLUP_DIS = 7;
    localparam int XC_XBAR_EN    = 6;

    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;
    localparam logic [2:0] SPI_PINS_3W = 3'h3;
    localparam logic [2:0] SPI_PINS_4W = 3'h4;

    localparam logic [7:0]  RST_LATCH  = 8'hFF;
    localparam logic [7:0]  RST_MDIN   = 8'hFF;
    localparam logic [7:0]  RST_MDOUT  = 8'h00;
    localparam logic [7:0]  RST_SKIP   = 8'h00;
    localparam logic [7:0]  RST_MASK   = 8'h00;
    localparam logic [7:0]  RST_MATCH  = 8'hFF;
    localparam logic [7:0]  RST_ROUTE  = 8'h00;
    localparam logic [7:0]  RST_DRIVE  = 8'h07;
    localparam logic [NUM_PINS-1:0] RST_PAD_SYNC = 24'hFFFFFF;

    typedef struct packed {
        logic       rd;
        logic       rmw;
        logic       wr;
        logic       bit_wr;
        logic [2:0] bit_sel;
        logic       bit_val;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pio_sfr_req_t;

    typedef struct packed {
        logic       clock_out;
        logic       cmp1_async;
        logic       cmp1;
        logic       cmp0_async;
        logic       cmp0;
        logic       smbus;
        logic       spi;
        logic       uart;
        logic       timer2;
        logic       timer1;
        logic       timer0;
        logic       counter_clock;
        logic [2:0] counter_channels;
    } pio_route_t;

    typedef struct packed {
        logic [NUM_PINS-1:0] stage1;
        logic [NUM_PINS-1:0] stage2;
    } pio_sync_t;

    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0]   latch;
        logic [NUM_PORTS-1:0][7:0]   mdin;
        logic [NUM_PORTS-1:0][7:0]   mdout;
        logic [NUM_PORTS-1:0][7:0]   skip;
        logic [MATCH_PORTS-1:0][7:0] mask;
        logic [MATCH_PORTS-1:0][7:0] match;
        logic [7:0]                  route_a;
        logic [7:0]                  route_b;
        logic [7:0]                  xbar_c;
        logic [7:0]                  drive_sel;
        logic [7:0]                  rdata;
        logic [NUM_PINS-1:0]         pad_out;
        logic [NUM_PINS-1:0]         pad_oe;
        logic [NUM_PINS-1:0]         pad_pullup;
        logic                        mismatch;
        logic                        wake;
        logic                        uart_rx;
        logic [2:0]                  spi_pins;
        pio_route_t                  route;
    } pio_state_t;

endpackage

// file: pio_sync.sv
// Two-stage synchroniser for the pad input levels
`timescale 1ns/1ps
module pio_sync (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rstn,
    input  wire logic [pio_pkg::NUM_PINS-1:0] i_async,
    output logic      [pio_pkg::NUM_PINS-1:0] o_sync
);
    pio_pkg::pio_sync_t st;
    pio_pkg::pio_sync_t next_st;

    // Stage one feeds only stage two; nothing else may look at it
    always_comb begin
        next_st        = st;
        next_st.stage1 = i_async;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st <= '{stage1: pio_pkg::RST_PAD_SYNC, stage2: pio_pkg::RST_PAD_SYNC};
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.stage2;
endmodule // pio_sync

// file: pio_top.sv
// Port I/O: pin modes, crossbar gating, port match and register file
`timescale 1ns/1ps
module pio_top (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rstn,
    input  wire pio_pkg::pio_sfr_req_t        i_sfr,
    output logic      [7:0]                   o_sfr_rdata,
    input  wire logic [pio_pkg::NUM_PINS-1:0] i_pad_in,
    output logic      [pio_pkg::NUM_PINS-1:0] o_pad_out,
    output logic      [pio_pkg::NUM_PINS-1:0] o_pad_oe,
    output logic      [pio_pkg::NUM_PINS-1:0] o_pad_pullup,
    output logic      [2:0]                   o_port_high_drive,
    input  wire logic [pio_pkg::NUM_PINS-1:0] i_periph_assign,
    input  wire logic [pio_pkg::NUM_PINS-1:0] i_periph_value,
    input  wire logic                         i_uart_tx,
    output logic                              o_uart_rx,
    input  wire logic                         i_spi_four_wire,
    output logic      [2:0]                   o_spi_pins,
    output pio_pkg::pio_route_t               o_route,
    input  wire logic                         i_idle,
    output logic                              o_mismatch,
    output logic                              o_wake_request
);
    pio_pkg::pio_state_t st;
    pio_pkg::pio_state_t next_st;
    logic [pio_pkg::NUM_PINS-1:0] pad_sync;

    localparam pio_pkg::pio_state_t ST_RESET = '{
        latch:      {pio_pkg::NUM_PORTS{pio_pkg::RST_LATCH}},
        mdin:       {pio_pkg::NUM_PORTS{pio_pkg::RST_MDIN}},
        mdout:      {pio_pkg::NUM_PORTS{pio_pkg::RST_MDOUT}},
        skip:       {pio_pkg::NUM_PORTS{pio_pkg::RST_SKIP}},
        mask:       {pio_pkg::MATCH_PORTS{pio_pkg::RST_MASK}},
        match:      {pio_pkg::MATCH_PORTS{pio_pkg::RST_MATCH}},
        route_a:    pio_pkg::RST_ROUTE,
        route_b:    pio_pkg::RST_ROUTE,
        xbar_c:     pio_pkg::RST_ROUTE,
        drive_sel:  pio_pkg::RST_DRIVE,
        rdata:      8'h00,
        pad_out:    '0,
        pad_oe:     '0,
        pad_pullup: '0,
        mismatch:   1'b0,
        wake:       1'b0,
        uart_rx:    1'b1,
        spi_pins:   3'h0,
        route:      '0
    };

    pio_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_async   (i_pad_in),
        .o_sync    (pad_sync)
    );

    // Byte write replaces the register, bit write touches one bit
    function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                           input pio_pkg::pio_sfr_req_t req,
                                           input logic [7:0] addr);
        logic [7:0] res;
        res = old;
        if (req.addr == addr) begin
            if (req.wr) begin
                res = req.wdata;
            end else if (req.bit_wr) begin
                res[req.bit_sel] = req.bit_val;
            end
        end
        return res;
    endfunction

    always_comb begin
        logic                         xbar_en;
        logic                         pull_dis;
        logic [pio_pkg::NUM_PINS-1:0] pin_view;
        logic                         value;
        logic                         drive_on;
        logic                         drv_low;
        logic                         drv_high;
        logic                         any_mis;
        logic [7:0]                   rd;
        int                           idx;
        xbar_en  = st.xbar_c[pio_pkg::XC_XBAR_EN];
        pull_dis = st.xbar_c[pio_pkg::XC_PULLUP_DIS];
        // Analog pins have their receiver off and read as zero
        pin_view = pad_sync & st.mdin;
        value    = 1'b0;
        drive_on = 1'b0;
        drv_low  = 1'b0;
        drv_high = 1'b0;
        any_mis  = 1'b0;
        rd       = 8'h00;
        idx      = 0;
        next_st  = st;

        // Register writes
        for (int p = 0; p < pio_pkg::NUM_PORTS; p++) begin
            next_st.latch[p] = wr_byte(st.latch[p], i_sfr, pio_pkg::ADDR_LATCH[p]);
            next_st.mdin[p]  = wr_byte(st.mdin[p], i_sfr, pio_pkg::ADDR_MDIN[p]);
            next_st.mdout[p] = wr_byte(st.mdout[p], i_sfr, pio_pkg::ADDR_MDOUT[p]);
            next_st.skip[p]  = wr_byte(st.skip[p], i_sfr, pio_pkg::ADDR_SKIP[p]);
        end
        for (int p = 0; p < pio_pkg::MATCH_PORTS; p++) begin
            next_st.mask[p]  = wr_byte(st.mask[p], i_sfr, pio_pkg::ADDR_MASK[p]);
            next_st.match[p] = wr_byte(st.match[p], i_sfr, pio_pkg::ADDR_MATCH[p]);
        end
        next_st.route_a = wr_byte(st.route_a, i_sfr, pio_pkg::ADDR_ROUTE_A);
        next_st.route_b = wr_byte(st.route_b, i_sfr, pio_pkg::ADDR_ROUTE_B)
                          & pio_pkg::ROUTE_B_RW_MASK;
        next_st.xbar_c  = wr_byte(st.xbar_c, i_sfr, pio_pkg::ADDR_XBAR_C)
                          & pio_pkg::XBAR_C_RW_MASK;
        next_st.drive_sel = wr_byte(st.drive_sel, i_sfr, pio_pkg::ADDR_DRIVE)
                            & pio_pkg::DRIVE_RW_MASK;

        // Pad cells
        for (int p = 0; p < pio_pkg::NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                idx   = p * 8 + b;
                value = st.latch[p][b];
                if (xbar_en && !st.skip[p][b] && idx < pio_pkg::XBAR_PINS) begin
                    if (i_periph_assign[idx]) begin
                        value = i_periph_value[idx];
                    end
                    if (st.route_a[pio_pkg::RA_UART] && idx == pio_pkg::UART_TX_PIN) begin
                        value = i_uart_tx;
                    end
                end
                // Crossbar pins stay undriven until the crossbar is on
                drive_on = st.mdin[p][b]
                           && !(idx < pio_pkg::XBAR_PINS && !xbar_en);
                drv_low  = drive_on && !value;
                drv_high = drive_on && st.mdout[p][b] && value;
                next_st.pad_out[idx]    = value;
                next_st.pad_oe[idx]     = drv_low || drv_high;
                next_st.pad_pullup[idx] = st.mdin[p][b] && !pull_dis
                                          && !(drv_low || drv_high);
            end
        end

        // Port match, independent of routing
        for (int p = 0; p < pio_pkg::MATCH_PORTS; p++) begin
            if (((pin_view[p*8 +: 8] ^ st.match[p]) & st.mask[p]) != 8'h00) begin
                any_mis = 1'b1;
            end
        end
        next_st.mismatch = any_mis;
        next_st.wake     = any_mis && i_idle;

        // Routing outputs
        next_st.route.clock_out     = xbar_en && st.route_a[pio_pkg::RA_CLOCK_OUT];
        next_st.route.cmp1_async    = xbar_en && st.route_a[pio_pkg::RA_CMP1_ASYN];
        next_st.route.cmp1          = xbar_en && st.route_a[pio_pkg::RA_CMP1];
        next_st.route.cmp0_async    = xbar_en && st.route_a[pio_pkg::RA_CMP0_ASYN];
        next_st.route.cmp0          = xbar_en && st.route_a[pio_pkg::RA_CMP0];
        next_st.route.smbus         = xbar_en && st.route_a[pio_pkg::RA_SMBUS];
        next_st.route.spi           = xbar_en && st.route_a[pio_pkg::RA_SPI];
        next_st.route.uart          = xbar_en && st.route_a[pio_pkg::RA_UART];
        next_st.route.timer2        = xbar_en && st.route_b[pio_pkg::RB_TIMER2];
        next_st.route.timer1        = xbar_en && st.route_b[pio_pkg::RB_TIMER1];
        next_st.route.timer0        = xbar_en && st.route_b[pio_pkg::RB_TIMER0];
        next_st.route.counter_clock = xbar_en && st.route_b[pio_pkg::RB_CNT_CLOCK];
        unique case (st.route_b[pio_pkg::RB_CHAN_HI:pio_pkg::RB_CHAN_LO])
            2'h0: next_st.route.counter_channels = 3'h0;
            2'h1: next_st.route.counter_channels = 3'h1;
            2'h2: next_st.route.counter_channels = 3'h3;
            2'h3: next_st.route.counter_channels = 3'h7;
        endcase
        if (!xbar_en) begin
            next_st.route.counter_channels = 3'h0;
        end
        if (xbar_en && st.route_a[pio_pkg::RA_SPI]) begin
            next_st.spi_pins = i_spi_four_wire ? pio_pkg::SPI_PINS_4W
                                               : pio_pkg::SPI_PINS_3W;
        end else begin
            next_st.spi_pins = 3'h0;
        end
        // Receive line idles high when not routed
        next_st.uart_rx = (xbar_en && st.route_a[pio_pkg::RA_UART]
                           && !st.skip[0][pio_pkg::UART_RX_PIN])
                          ? pin_view[pio_pkg::UART_RX_PIN] : 1'b1;

        // Register reads, answered one cycle later; unmapped reads zero
        if (i_sfr.rd) begin
            for (int p = 0; p < pio_pkg::NUM_PORTS; p++) begin
                if (i_sfr.addr == pio_pkg::ADDR_LATCH[p]) begin
                    rd = i_sfr.rmw ? (st.latch[p] & st.mdin[p])
                                   : pin_view[p*8 +: 8];
                end
                if (i_sfr.addr == pio_pkg::ADDR_MDIN[p]) begin
                    rd = st.mdin[p];
                end
                if (i_sfr.addr == pio_pkg::ADDR_MDOUT[p]) begin
                    rd = st.mdout[p];
                end
                if (i_sfr.addr == pio_pkg::ADDR_SKIP[p]) begin
                    rd = st.skip[p];
                end
            end
            for (int p = 0; p < pio_pkg::MATCH_PORTS; p++) begin
                if (i_sfr.addr == pio_pkg::ADDR_MASK[p]) begin
                    rd = st.mask[p];
                end
                if (i_sfr.addr == pio_pkg::ADDR_MATCH[p]) begin
                    rd = st.match[p];
                end
            end
            if (i_sfr.addr == pio_pkg::ADDR_ROUTE_A) begin
                rd = st.route_a;
            end
            if (i_sfr.addr == pio_pkg::ADDR_ROUTE_B) begin
                rd = st.route_b;
            end
            if (i_sfr.addr == pio_pkg::ADDR_XBAR_C) begin
                rd = st.xbar_c;
            end
            if (i_sfr.addr == pio_pkg::ADDR_DRIVE) begin
                rd = st.drive_sel;
            end
            next_st.rdata = rd;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_sfr_rdata       = st.rdata;
    assign o_pad_out         = st.pad_out;
    assign o_pad_oe          = st.pad_oe;
    assign o_pad_pullup      = st.pad_pullup;
    assign o_port_high_drive = st.drive_sel[2:0];
    assign o_uart_rx         = st.uart_rx;
    assign o_spi_pins        = st.spi_pins;
    assign o_route           = st.route;
    assign o_mismatch        = st.mismatch;
    assign o_wake_request    = st.wake;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    analog_undriven_a: assert property (
        (o_pad_oe & ~$past(st.mdin)) == '0
    ) else $error("analog pin has its driver on");

    opendrain_high_a: assert property (
        (o_pad_oe & o_pad_out & ~$past(st.mdout)) == '0
    ) else $error("open-drain pin drives high");

    pushpull_drive_a: assert property (
        ($past(st.mdin[2][0]) && $past(st.mdout[2][0]))
        |-> o_pad_oe[16] && (o_pad_out[16] == $past(st.latch[2][0]))
    ) else $error("push-pull pin not driven from latch");

    xbar_off_a: assert property (
        !$past(st.xbar_c[pio_pkg::XC_XBAR_EN]) |-> o_pad_oe[pio_pkg::XBAR_PINS-1:0] == '0
    ) else $error("crossbar pin driven before crossbar enable");

    pullup_gate_a: assert property (
        $past(st.xbar_c[pio_pkg::XC_PULLUP_DIS]) |-> o_pad_pullup == '0
    ) else $error("pull-up on while globally disabled");

    pullup_drive_a: assert property (
        (o_pad_pullup & o_pad_oe) == '0
    ) else $error("pull-up on while pin driven");

    drive_reset_a: assert property (disable iff (1'b0)
        !i_rstn |=> o_port_high_drive == 3'h7
    ) else $error("drive strength not high after reset");

    mismatch_pins_a: assert property (
        ($past(i_rstn, 3) && $past(i_rstn, 2) && $past(i_rstn))
        |-> o_mismatch == ((((($past(i_pad_in, 3) & $past(st.mdin)) ^ $past(st.match[0]))
                             & $past(st.mask[0])) != 8'h00)
                           || (((($past(i_pad_in[15:8], 3) & $past(st.mdin[1]))
                                ^ $past(st.match[1])) & $past(st.mask[1])) != 8'h00))
    ) else $error("mismatch does not follow masked pin compare");

    rmw_latch_a: assert property (
        $past(i_sfr.rd && i_sfr.rmw && i_sfr.addr == pio_pkg::ADDR_LATCH[1])
        |-> o_sfr_rdata == $past(st.latch[1] & st.mdin[1])
    ) else $error("read-modify-write did not read latch");

    pin_read_a: assert property (
        $past(i_sfr.rd && !i_sfr.rmw && i_sfr.addr == pio_pkg::ADDR_LATCH[1])
        |-> o_sfr_rdata == $past(pad_sync[15:8] & st.mdin[1])
    ) else $error("port read did not return pin levels");

    uart_tx_pin_a: assert property (
        $past(st.xbar_c[pio_pkg::XC_XBAR_EN] && st.route_a[pio_pkg::RA_UART]
              && !st.skip[0][pio_pkg::UART_TX_PIN])
        |-> o_pad_out[pio_pkg::UART_TX_PIN] == $past(i_uart_tx)
    ) else $error("uart transmit not on its fixed pin");

    channel_route_a: assert property (
        ($past(st.xbar_c[pio_pkg::XC_XBAR_EN]) && $past(st.route_b[1:0]) == 2'h2)
        |-> o_route.counter_channels == 3'h3
    ) else $error("counter channel route field decode wrong");

    wake_level_a: assert property (
        o_wake_request == (o_mismatch && $past(i_idle))
    ) else $error("wake request not mismatch during idle");

    spi_pins_a: assert property (
        $past(st.xbar_c[pio_pkg::XC_XBAR_EN] && st.route_a[pio_pkg::RA_SPI])
        |-> o_spi_pins == ($past(i_spi_four_wire) ? pio_pkg::SPI_PINS_4W : pio_pkg::SPI_PINS_3W)
    ) else $error("spi pin count wrong for wire mode");

    analog_pullup_a: assert property (
        (o_pad_pullup & ~$past(st.mdin)) == '0
    ) else $error("analog pin has its pull-up on");

    route_b_rsvd_a: assert property (
        $past(i_sfr.rd && i_sfr.addr == pio_pkg::ADDR_ROUTE_B) |-> o_sfr_rdata[7:6] == 2'h0
    ) else $error("reserved route bits read back set");

    route_gate_a: assert property (
        !$past(st.xbar_c[pio_pkg::XC_XBAR_EN]) |-> o_route == '0
    ) else $error("route enable active with crossbar off");

    latch_write_a: assert property (
        $past(i_sfr.wr && i_sfr.addr == pio_pkg::ADDR_LATCH[2])
        |-> st.latch[2] == $past(i_sfr.wdata)
    ) else $error("byte write did not reach output latch");

    uart_rx_idle_a: assert property (
        !$past(st.route_a[pio_pkg::RA_UART]) |-> o_uart_rx
    ) else $error("uart receive not idle while unrouted");

    opendrain_low_a: assert property (
        $past(st.mdin[2][5] && !st.mdout[2][5] && !st.latch[2][5])
        |-> o_pad_oe[21] && !o_pad_out[21]
    ) else $error("open-drain pin not pulled low by latch zero");

    skip_gate_a: assert property (
        $past(st.skip[0][0] && st.latch[0][0]) |-> o_pad_out[0]
    ) else $error("crossbar function reached a skipped pin");

    mismatch_seen_c: cover property ($rose(o_mismatch));
    rmw_read_c:      cover property (i_sfr.rd && i_sfr.rmw);
    uart_route_c:    cover property (o_route.uart && o_pad_oe[pio_pkg::UART_TX_PIN]);
    wake_c:          cover property (o_wake_request);
endmodule // pio_top

// file: pio_pad_model.sv
// Pad level model of the circuitry attached to the port pins
`timescale 1ns/1ps
module pio_pad_model (
    input  wire logic        i_clk_sys,
    input  wire logic [23:0] i_pad_out,
    input  wire logic [23:0] i_pad_oe,
    input  wire logic [23:0] i_pad_pullup,
    input  wire logic [23:0] i_ext_en,
    input  wire logic [23:0] i_ext_val,
    output logic      [23:0] o_pad
);
    logic [23:0] prev = 24'h000000;
    // A pad that nobody drives or pulls drifts away from its last level
    always_ff @(posedge i_clk_sys) prev <= o_pad;
    assign o_pad = (i_pad_oe & i_pad_out)
                 | (~i_pad_oe & i_ext_en & i_ext_val)
                 | (~i_pad_oe & ~i_ext_en & i_pad_pullup)
                 | (~i_pad_oe & ~i_ext_en & ~i_pad_pullup & ~prev);
endmodule // pio_pad_model

// file: testbench.sv
// Self-checking testbench for the port I/O block
`timescale 1ns/1ps
module testbench;
    logic i_clk_sys = 1'h0, i_rstn = 1'h0, utx = 1'h1, four = 1'h1, idle = 1'h0, urx, mism, wake;
    pio_pkg::pio_sfr_req_t sfr = '0;
    pio_pkg::pio_route_t   route;
    logic [23:0] ext_en = 24'h0, ext_val = 24'h0, pas = 24'h0, pval = 24'h0, pad, pout, poe, ppu;
    logic [7:0]  rdata;
    logic [2:0]  hdrv, spins;
    int          num_errors = 0, total_checks = 0;
    initial forever #50 i_clk_sys = ~i_clk_sys;
    pio_top dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_sfr(sfr), .o_sfr_rdata(rdata),
        .i_pad_in(pad), .o_pad_out(pout), .o_pad_oe(poe), .o_pad_pullup(ppu),
        .o_port_high_drive(hdrv), .i_periph_assign(pas), .i_periph_value(pval),
        .i_uart_tx(utx), .o_uart_rx(urx), .i_spi_four_wire(four), .o_spi_pins(spins),
        .o_route(route), .i_idle(idle), .o_mismatch(mism), .o_wake_request(wake));
    pio_pad_model pads (.i_clk_sys(i_clk_sys), .i_pad_out(pout), .i_pad_oe(poe),
        .i_pad_pullup(ppu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
    task automatic complete_run();
        if (num_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    // Neither strobe set means a bit write: d[2:0] picks the bit, d[3] is its value
    task automatic bus(input logic r, m, w, input logic [7:0] a, d);
        @(negedge i_clk_sys);
        sfr = '{rd: r, rmw: m, wr: w, bit_wr: !r && !w, bit_sel: d[2:0], bit_val: d[3],
                addr: a, wdata: d};
        @(negedge i_clk_sys);
        sfr = '0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(1'h0, 1'h0, 1'h1, a, d);
    endtask
    task automatic rd(input logic m, input logic [7:0] a, e);
        bus(1'h1, m, 1'h0, a, 8'h00);
        chk("rdata", {16'h0000, rdata}, {16'h0000, e});
    endtask
    task automatic t_reset();
        chk("drive", {21'h0, hdrv}, 24'h000007);
        chk("pullup", ppu, 24'hFFFFFF);
        rd(1'h0, 8'hE1, 8'h00);
        rd(1'h0, 8'hE2, 8'h00);
        rd(1'h0, 8'h55, 8'h00);
    endtask
    task automatic t_modes();
        wr(8'hC6, 8'h0F);
        wr(8'hA0, 8'h55);
        wt(1);
        chk("oe p2", {16'h0, poe[23:16]}, 24'h0000AF);
        chk("out p2", {20'h0, pout[19:16]}, 24'h000005);
        chk("pullup p2", {16'h0, ppu[23:16]}, 24'h000050);
        wr(8'hF3, 8'h80);
        wt(1);
        chk("pullup off", ppu, 24'h000000);
        wr(8'hF3, 8'h00);
        wr(8'hF6, 8'hFA);
        chk("drive wr", {21'h0, hdrv}, 24'h000002);
    endtask
    task automatic t_read();
        ext_en[15:8] = 8'hFF;
        ext_val[15:8] = 8'h3C;
        wt(3);
        rd(1'h0, 8'h90, 8'h3C);
        bus(1'h0, 1'h0, 1'h0, 8'h90, 8'h01);
        rd(1'h1, 8'h90, 8'hFD);
        wr(8'h90, 8'hFF);
        wr(8'hC2, 8'h0F);
        wt(3);
        rd(1'h0, 8'h90, 8'h0C);
        chk("pullup p1", {16'h0, ppu[15:8]}, 24'h00000F);
        wr(8'hC2, 8'hFF);
    endtask
    task automatic t_match();
        wr(8'hEE, 8'h01);
        wr(8'hED, 8'h00);
        idle = 1'h1;
        ext_val[8] = 1'h1;
        wt(2);
        chk("mismatch early", {23'h0, mism}, 24'h000000);
        wt(2);
        chk("mismatch", {23'h0, mism}, 24'h000001);
        chk("wake", {23'h0, wake}, 24'h000001);
        idle = 1'h0;
    endtask
    task automatic t_route();
        logic [2:0] th [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        pas[0] = 1'h1;
        wt(1);
        chk("oe gated", {23'h0, poe[0]}, 24'h000000);
        wr(8'hF3, 8'h40);
        wr(8'hE1, 8'hFF);
        wr(8'hE2, 8'hFF);
        rd(1'h0, 8'hE2, 8'h3F);
        chk("oe periph", {23'h0, poe[0]}, 24'h000001);
        chk("route a", {16'h0, route[14:7]}, 24'h0000FF);
        chk("route b", {20'h0, route[6:3]}, 24'h00000F);
        chk("spi4", {21'h0, spins}, 24'h000004);
        for (int i = 0; i < 4; i++) begin
            wr(8'hE2, 8'(i));
            wt(1);
            chk("channels", {21'h0, route.counter_channels}, {21'h0, th[i]});
        end
        four = 1'h0;
        utx = 1'h0;
        ext_en[5] = 1'h1;
        wt(4);
        chk("spi3", {21'h0, spins}, 24'h000003);
        chk("uart tx", {22'h0, poe[4], pout[4]}, 24'h000002);
        chk("uart rx", {23'h0, urx}, 24'h000000);
        wr(8'hD4, 8'h01);
        wt(1);
        chk("skip", {23'h0, poe[0]}, 24'h000000);
    endtask
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        num_errors++;
        complete_run();
    end
    initial begin
        wt(20);
        i_rstn = 1'h1;
        wt(2);
        t_reset();
        t_modes();
        t_read();
        t_match();
        t_route();
        complete_run();
    end
endmodule // testbench
